/* File: design/qwn_params.svh */
`ifndef QWN_PARAMS_SVH
`define QWN_PARAMS_SVH

// System clock period in ns (10 MHz)
`define QWN_CLK_PERIOD_NS 100
// Erase/write cycle time in us, as printed
`define QWN_T_BUSY_US 4000
// Erase/write cycle in system clock cycles (rounded down)
`define QWN_BUSY_CYCLES ((`QWN_T_BUSY_US * 1000) / `QWN_CLK_PERIOD_NS)
// Wiper code width and channel count
`define QWN_WIPER_W 8
`define QWN_CHANNELS 4
`define QWN_ADDR_BITS 2
// Index of the last data bit and of the last address bit
`define QWN_LAST_DATA_IDX 3'h7
`define QWN_LAST_ADDR_IDX 3'h1
// Stored setting before anything is ever programmed
`define QWN_NVM_INIT 8'h80
// Pin bundle synchronised into the system clock domain
`define QWN_SYNC_W 5
`define QWN_PIN_SCLK 0
`define QWN_PIN_CS 1
`define QWN_PIN_DIN 2
`define QWN_PIN_STORE_REQUEST 3
`define QWN_PIN_VOK 4

`endif

/* File: design/qwn_pkg.sv */
`include "qwn_params.svh"

package qwn_pkg;
  // One wiper code
  typedef logic [`QWN_WIPER_W-1:0] qwn_code_t;
  // Channel index
  typedef logic [`QWN_ADDR_BITS-1:0] qwn_chan_t;
  // All four wiper codes
  typedef logic [`QWN_CHANNELS-1:0][`QWN_WIPER_W-1:0] qwn_bank_t;
  // Serial frame progress
  typedef enum logic [2:0] {
    FR_IDLE,
    FR_ADDR,
    FR_DATA,
    FR_COMMIT,
    FR_GAP
  } qwn_frame_t;
endpackage : qwn_pkg

/* File: design/qwn_sync.sv */
module qwn_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [W-1:0] async_in, // Pins from outside the domain
  output logic [W-1:0] sync_out // Two-stage synchronised copy
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two flip-flops per bit; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // qwn_sync

/* File: design/qwn_nvm.sv */
`include "qwn_params.svh"

module qwn_nvm (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic wr_en, // Store one code, one-cycle pulse
  input wire qwn_pkg::qwn_chan_t wr_chan, // Channel to store
  input wire qwn_pkg::qwn_code_t wr_code, // Code to store
  output qwn_pkg::qwn_bank_t rd_bank // Stored codes, registered
);
  import qwn_pkg::*;

  qwn_bank_t cell_q;
  qwn_bank_t rd_q;

  // Non-volatile cells and registered read port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_q <= {`QWN_CHANNELS{`QWN_NVM_INIT}};
      rd_q <= {`QWN_CHANNELS{`QWN_NVM_INIT}};
    end else begin
      if (wr_en) begin
        cell_q[wr_chan] <= wr_code;
      end
      rd_q <= cell_q;
    end
  end

  assign rd_bank = rd_q;
endmodule // qwn_nvm

/* File: design/qwn_top.sv */
`include "qwn_params.svh"

module qwn_top #(
  parameter int BUSY_CYCLES = `QWN_BUSY_CYCLES
) (
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic ser_clk, // Serial clock pin
  input wire logic chip_sel, // Chip select pin, active high
  input wire logic serial_in, // Serial data pin
  input wire logic store_request, // Program request pin
  input wire logic supply_ok, // Supply high enough to program
  output logic serial_out, // Serial data out
  output logic serial_out_oe, // Drive enable for serial_out
  output logic ready_busy_n, // Low while programming
  output qwn_pkg::qwn_bank_t wiper_channel // Four wiper codes
);
  import qwn_pkg::*;

  localparam int CW = $clog2(BUSY_CYCLES + 1);

  logic [`QWN_SYNC_W-1:0] pin_s;
  logic sclk_s, cs_s, din_s, store_request_s, vok_s;
  logic sclk_prev_q, cs_prev_q, store_request_prev_q;
  logic sck_rise, cs_fall, store_request_rise;
  qwn_bank_t nvm_rd;

  qwn_frame_t state_q, state_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  qwn_chan_t addr_q, addr_d;
  qwn_code_t data_q, data_d;
  qwn_code_t out_sh_q, out_sh_d;
  logic sout_q, sout_d;
  logic oe_q, oe_d;
  qwn_bank_t wiper_q, wiper_d;
  qwn_chan_t store_request_chan_q, store_request_chan_d;
  qwn_code_t store_request_data_q, store_request_data_d;
  logic store_request_valid_q, store_request_valid_d;
  logic store_req_q, store_req_d;
  logic load_pend_q, load_pend_d;
  logic start_busy;

  logic ready_q, ready_d;
  logic [CW-1:0] busy_cnt_q, busy_cnt_d;
  logic nvm_we;

  // Pins into the system clock domain
  qwn_sync #(
    .W(`QWN_SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({supply_ok, store_request, serial_in, chip_sel, ser_clk}),
    .sync_out(pin_s)
  );

  // Stored settings
  qwn_nvm u_nvm (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(nvm_we),
    .wr_chan(store_request_chan_q),
    .wr_code(store_request_data_q),
    .rd_bank(nvm_rd)
  );

  // Named views of the synchronised pins
  assign sclk_s = pin_s[`QWN_PIN_SCLK];
  assign cs_s = pin_s[`QWN_PIN_CS];
  assign din_s = pin_s[`QWN_PIN_DIN];
  assign store_request_s = pin_s[`QWN_PIN_STORE_REQUEST];
  assign vok_s = pin_s[`QWN_PIN_VOK];

  // Edge detection on synchronised levels
  assign sck_rise = sclk_s & ~sclk_prev_q;
  assign cs_fall = ~cs_s & cs_prev_q;
  assign store_request_rise = store_request_s & ~store_request_prev_q;

  // Busy starts on the commit edge of an armed frame with good supply
  assign start_busy = cs_s & ready_q & sck_rise & (state_q == FR_COMMIT)
                      & store_req_q & vok_s;

  // Programming cycle timer and ready/busy
  always_comb begin
    ready_d = ready_q;
    busy_cnt_d = busy_cnt_q;
    nvm_we = 1'b0;
    if (start_busy) begin
      ready_d = 1'b0;
      busy_cnt_d = CW'(BUSY_CYCLES - 1);
    end else if (!ready_q) begin
      if (busy_cnt_q == '0) begin
        ready_d = 1'b1;
        nvm_we = 1'b1;
      end else begin
        busy_cnt_d = busy_cnt_q - 1'b1;
      end
    end
  end

  // Busy state registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b1;
      busy_cnt_q <= '0;
    end else begin
      ready_q <= ready_d;
      busy_cnt_q <= busy_cnt_d;
    end
  end

  // Frame receiver, read-back shifter and wiper bank
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    out_sh_d = out_sh_q;
    sout_d = sout_q;
    wiper_d = wiper_q;
    store_request_chan_d = store_request_chan_q;
    store_request_data_d = store_request_data_q;
    store_request_valid_d = store_request_valid_q;
    store_req_d = store_req_q;
    load_pend_d = 1'b0;
    oe_d = cs_s & ready_d;
    if (load_pend_q) begin
      wiper_d = nvm_rd;
    end
    if (!cs_s) begin
      state_d = FR_IDLE;
      store_req_d = 1'b0;
      sout_d = 1'b0;
      if (cs_fall) begin
        wiper_d = nvm_rd;
        store_request_valid_d = 1'b0;
      end
    end else if (!ready_q) begin
      state_d = FR_IDLE;
      sout_d = 1'b0;
    end else begin
      if (store_request_rise && (state_q == FR_ADDR || state_q == FR_DATA)) begin
        store_req_d = 1'b1;
      end
      if (sck_rise) begin
        unique case (state_q)
          FR_IDLE: begin
            if (din_s) begin
              state_d = FR_ADDR;
              bit_cnt_d = '0;
            end
          end
          FR_ADDR: begin
            addr_d = {din_s, addr_q[1]};
            bit_cnt_d = bit_cnt_q + 1'b1;
            if (bit_cnt_q == `QWN_LAST_ADDR_IDX) begin
              state_d = FR_DATA;
              bit_cnt_d = '0;
              out_sh_d = wiper_q[{din_s, addr_q[1]}];
              sout_d = wiper_q[{din_s, addr_q[1]}][0];
            end
          end
          FR_DATA: begin
            data_d = {din_s, data_q[7:1]};
            out_sh_d = {1'b0, out_sh_q[7:1]};
            sout_d = out_sh_q[1];
            bit_cnt_d = bit_cnt_q + 1'b1;
            if (bit_cnt_q == `QWN_LAST_DATA_IDX) begin
              state_d = FR_COMMIT;
            end
          end
          FR_COMMIT: begin
            wiper_d[addr_q] = data_q;
            store_request_chan_d = addr_q;
            store_request_data_d = data_q;
            store_request_valid_d = 1'b1;
            store_req_d = 1'b0;
            sout_d = 1'b0;
            // A started store goes straight to idle while busy
            state_d = start_busy ? FR_IDLE : FR_GAP;
          end
          FR_GAP: begin
            if (!start_busy) begin
              store_request_valid_d = 1'b0;
            end
            state_d = FR_IDLE;
          end
        endcase
      end
    end
  end

  // Frame and wiper registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
      store_request_prev_q <= 1'b0;
      state_q <= FR_IDLE;
      bit_cnt_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      out_sh_q <= '0;
      sout_q <= 1'b0;
      oe_q <= 1'b0;
      wiper_q <= '0;
      store_request_chan_q <= '0;
      store_request_data_q <= '0;
      store_request_valid_q <= 1'b0;
      store_req_q <= 1'b0;
      load_pend_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
      store_request_prev_q <= store_request_s;
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      out_sh_q <= out_sh_d;
      sout_q <= sout_d;
      oe_q <= oe_d;
      wiper_q <= wiper_d;
      store_request_chan_q <= store_request_chan_d;
      store_request_data_q <= store_request_data_d;
      store_request_valid_q <= store_request_valid_d;
      store_req_q <= store_req_d;
      load_pend_q <= load_pend_d;
    end
  end

  // Outputs straight from flip-flops
  assign serial_out = sout_q;
  assign serial_out_oe = oe_q;
  assign ready_busy_n = ready_q;
  assign wiper_channel = wiper_q;

  // Output released one cycle after deselect
  oe_off_cs_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !cs_s |=> !serial_out_oe)
    else $error("serial output driven while deselected");

  // No drive while programming
  oe_off_busy_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !ready_busy_n |-> !serial_out_oe && state_q == FR_IDLE)
    else $error("serial output driven while busy");

  // Deselect restores every stored code
  cs_reload_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cs_fall |=> wiper_channel == $past(nvm_rd))
    else $error("wipers not reloaded on deselect");

  // First one bit while selected opens a frame
  start_bit_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cs_s && ready_q && sck_rise && state_q == FR_IDLE && din_s
    |=> state_q == FR_ADDR && bit_cnt_q == 3'h0)
    else $error("start bit not taken");

  // Data enters at the top, so the first bit ends lowest
  data_lsb_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cs_s && ready_q && sck_rise && state_q == FR_DATA
    |=> data_q[7] == $past(din_s) && data_q[6:0] == $past(data_q[7:1]))
    else $error("data not assembled LSB first");

  // Old code appears on the output after the address
  read_first_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cs_s && ready_q && sck_rise && state_q == FR_ADDR && bit_cnt_q == 3'h1
    |=> serial_out == $past(wiper_q[{din_s, addr_q[1]}][0])
        && state_q == FR_DATA)
    else $error("read-back bit zero wrong");

  // Addressed wiper takes the code on the edge after the last bit
  commit_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cs_s && ready_q && sck_rise && state_q == FR_COMMIT
    |=> wiper_q[$past(addr_q)] == $past(data_q)
        && state_q == ($past(start_busy) ? FR_IDLE : FR_GAP))
    else $error("wiper not updated after last data bit");

  // No store during the first eight cycles of busy
  busy_hold_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $fell(ready_busy_n) |-> !nvm_we [*8])
    else $error("programming cycle ended early");

  // Low supply leaves ready/busy high
  low_supply_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cs_s && ready_q && sck_rise && state_q == FR_COMMIT && !vok_s
    |=> ready_busy_n)
    else $error("busy raised with low supply");

  // Unstored programming data dropped on the second edge
  discard_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cs_s && ready_q && sck_rise && state_q == FR_GAP && !start_busy
    |=> !store_request_valid_q && state_q == FR_IDLE)
    else $error("programming data kept without store");

endmodule // qwn_top

/* File: bench/qwn_host.sv */
module qwn_host (
  input wire logic sys_clk, // System clock
  output logic ser_clk, // Serial clock pin
  output logic chip_sel, // Chip select pin
  output logic serial_in, // Serial data pin
  output logic store_request, // Program request pin
  input wire logic serial_out, // Device data out
  input wire logic serial_out_oe // Device drive enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line_q = 1'b0; // Level seen on the shared data line

  // Released line has no pull, so it keeps changing
  always @(posedge sys_clk) begin
    line_q <= serial_out_oe ? serial_out : ~line_q;
  end

  // Serial clock stands still between frames
  initial begin
    ser_clk = 1'b0;
    chip_sel = 1'b0;
    serial_in = 1'b0;
    store_request = 1'b0;
  end

  // Wait n system edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Chip select change with time for the device to see it
  task automatic select(input logic on);
    chip_sel = on;
    tick(6);
  endtask

  // One serial clock period, 500 ns high and low
  task automatic spin();
    ser_clk = 1'b1;
    tick(5);
    ser_clk = 1'b0;
    tick(5);
  endtask

  // Clock periods with the data line low before a frame
  task automatic zeros(input int n);
    serial_in = 1'b0;
    repeat (n) spin();
  endtask

  // Program request dropped after the store
  task automatic drop();
    store_request = 1'b0;
  endtask

  // Frame of given rise count; gathers the read-back bits
  task automatic xfer(input logic [1:0] ch, input logic [7:0] d,
                      input int rises, input logic arm,
                      output logic [7:0] old);
    logic [10:0] bits;
    bits = {d, ch, 1'b1};
    old = 8'h00;
    // Rise 12 commits the code, rise 13 gives the inter-frame gap
    for (int i = 0; i < rises; i++) begin
      serial_in = (i < 11) ? bits[i] : 1'b0;
      if (arm && i == 4) begin
        store_request = 1'b1;
      end
      spin();
      if (i >= 2 && i <= 9) begin
        old[i-2] = line_q;
      end
    end
  endtask
endmodule // qwn_host

/* File: bench/test_quad_wiper_serial_nvm_control.sv */
module test_quad_wiper_serial_nvm_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset_n, supply_ok;
  // Nets driven by the host model and by the design
  wire ser_clk, chip_sel, serial_in, store_request;
  wire serial_out, serial_out_oe, ready_busy_n;
  wire qwn_pkg::qwn_bank_t wiper_channel;
  int miscompares, checked;
  logic [7:0] old;

  qwn_top #(.BUSY_CYCLES(20)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .ser_clk(ser_clk),
    .chip_sel(chip_sel), .serial_in(serial_in),
    .store_request(store_request), .supply_ok(supply_ok),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .ready_busy_n(ready_busy_n), .wiper_channel(wiper_channel)
  );

  qwn_host host (
    .sys_clk(sys_clk), .ser_clk(ser_clk), .chip_sel(chip_sel),
    .serial_in(serial_in), .store_request(store_request),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );

  // 10 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Outputs straight after reset
  task automatic power_up();
    check(wiper_channel, {4{8'h80}});
    check(ready_busy_n, 1);
    check(serial_out_oe, 0);
  endtask

  // Temporary writes to every channel, then deselect
  task automatic temp_writes();
    qwn_pkg::qwn_bank_t exp;
    logic [7:0] d;
    exp = {4{8'h80}};
    host.select(1'b1);
    check(serial_out_oe, 1);
    for (int c = 0; c < 4; c++) begin
      d = 8'h3c + 8'(c * 8'h41);
      host.xfer(c[1:0], d, 13, 1'b0, old);
      check(old, 8'h80);
      exp[c] = d;
      check(wiper_channel, exp);
    end
    host.xfer(2'b10, 8'h01, 13, 1'b0, old);
    check(old, exp[2]);
    exp[2] = 8'h01;
    check(wiper_channel, exp);
    host.select(1'b0);
    check(wiper_channel, {4{8'h80}});
    check(serial_out_oe, 0);
  endtask

  // Zeros before the start bit are skipped
  task automatic start_search();
    host.select(1'b1);
    host.zeros(3);
    host.xfer(2'b01, 8'h96, 13, 1'b0, old);
    check(wiper_channel[1], 8'h96);
    host.select(1'b0);
  endtask

  // Read only: deselect before the commit rise
  task automatic early_read();
    host.select(1'b1);
    host.xfer(2'b11, 8'h11, 13, 1'b0, old);
    host.xfer(2'b11, 8'hee, 11, 1'b0, old);
    check(old, 8'h11);
    check(wiper_channel[3], 8'h11);
    host.select(1'b0);
    check(wiper_channel[3], 8'h80);
  endtask

  // Store with supply good or low, then reload to see the cell
  task automatic store(input logic ok, input logic [7:0] d,
                       input logic [7:0] exp);
    int n;
    supply_ok = ok;
    host.select(1'b1);
    host.xfer(2'b01, d, 12, 1'b1, old);
    check(ready_busy_n, !ok);
    if (ok) begin
      check(serial_out_oe, 0);
    end
    n = 0;
    // Clock and request kept up until ready returns
    while (ready_busy_n !== 1'b1) begin
      host.spin();
      n++;
      if (n > 10) begin
        miscompares++;
        conclude();
      end
    end
    host.spin();
    host.drop();
    host.select(1'b0);
    check(wiper_channel[1], exp);
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    supply_ok = 1'b1;
    miscompares = 0;
    checked = 0;
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    host.tick(3);
    power_up();
    temp_writes();
    start_search();
    early_read();
    store(1'b1, 8'h5b, 8'h5b);
    store(1'b0, 8'hd4, 8'h5b);
    conclude();
  end
endmodule // test_quad_wiper_serial_nvm_control
